// >>> thc_bank.sv
// apb register bank for transmit error insertion status and packet and byte counters
`timescale 1ns/1ps
`default_nettype none
module thc_bank (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire thc_pkg::thc_apb_req_type apb_req,
	output var  thc_pkg::thc_apb_rsp_type apb_rsp,
	input  wire thc_pkg::thc_tx_event_type tx_ev,
	output logic                          irq,
	output logic                          manual_error_insert
);
	import thc_pkg::*;

	// ************************************************************
	// decode
	// ************************************************************

	// true when a byte address selects the register of this index
	function automatic logic thc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		thc_hit = (a == {2'b00, idx, 2'b00});
	endfunction

	// true when a byte address selects any mapped register
	function automatic logic thc_mapped(input logic [ADDR_W-1:0] a);
		thc_mapped = thc_hit(a, IDX_STATUS) | thc_hit(a, IDX_LATCHED)
			| thc_hit(a, IDX_IRQ_ENABLE) | thc_hit(a, IDX_IRQ_CLEAR)
			| thc_hit(a, IDX_PKT_B0) | thc_hit(a, IDX_PKT_B1) | thc_hit(a, IDX_PKT_B2)
			| thc_hit(a, IDX_BYTE_B0) | thc_hit(a, IDX_BYTE_B1)
			| thc_hit(a, IDX_BYTE_B2) | thc_hit(a, IDX_BYTE_B3)
			| thc_hit(a, IDX_MANUAL) | thc_hit(a, IDX_UPD_REQUEST)
			| thc_hit(a, IDX_UPD_STATUS);
	endfunction

	thc_state_type state_reg;
	thc_state_type state_next;

	logic setup_ph;
	logic wr_acc;
	logic rd_acc;
	logic upd_rise;
	logic manual_rise;
	logic fin_set;
	logic fin_clear;
	logic latch_clear;

	// bus phases
	assign setup_ph = apb_req.psel & ~apb_req.penable;
	assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_acc   = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

	// register events decoded at the access edge
	assign upd_rise = wr_acc & thc_hit(apb_req.paddr, IDX_UPD_REQUEST)
		& apb_req.pwdata[BIT_FLAG] & ~state_reg.counter_update_request;
	assign manual_rise = wr_acc & thc_hit(apb_req.paddr, IDX_MANUAL)
		& apb_req.pwdata[BIT_FLAG] & ~state_reg.manual_error_strobe;
	assign latch_clear = (rd_acc & thc_hit(apb_req.paddr, IDX_LATCHED))
		| (wr_acc & thc_hit(apb_req.paddr, IDX_IRQ_CLEAR) & apb_req.pwdata[BIT_FLAG]);

	// finished detection from the errored packet stream
	assign fin_clear = tx_ev.auto_insert_initiate | tx_ev.insertion_disabled;
	assign fin_set   = tx_ev.errored_packet_sent
		& (tx_ev.errored_packet_total != TOTAL_CONTINUOUS)
		& ((state_reg.errored_sent_cnt + CNT_ONE8) == tx_ev.errored_packet_total);

	// ************************************************************
	// next state
	// ************************************************************

	// all register updates in one place
	always_comb begin
		state_next = state_reg;

		// read data and error captured in the setup cycle
		if (setup_ph) begin
			state_next.prdata  = '0;
			state_next.pslverr = ~thc_mapped(apb_req.paddr);
			if (!apb_req.pwrite) begin
				unique case (1'b1)
					thc_hit(apb_req.paddr, IDX_STATUS):
						state_next.prdata[BIT_FLAG] = state_reg.insertion_finished;
					thc_hit(apb_req.paddr, IDX_LATCHED):
						state_next.prdata[BIT_FLAG] = state_reg.insertion_finished_latched;
					thc_hit(apb_req.paddr, IDX_IRQ_ENABLE):
						state_next.prdata[BIT_FLAG] = state_reg.insertion_finished_irq_en;
					thc_hit(apb_req.paddr, IDX_PKT_B0):
						state_next.prdata[7:0] = state_reg.packet_counter[7:0];
					thc_hit(apb_req.paddr, IDX_PKT_B1):
						state_next.prdata[7:0] = state_reg.packet_counter[15:8];
					thc_hit(apb_req.paddr, IDX_PKT_B2):
						state_next.prdata[7:0] = state_reg.packet_counter[23:16];
					thc_hit(apb_req.paddr, IDX_BYTE_B0):
						state_next.prdata[7:0] = state_reg.byte_counter[7:0];
					thc_hit(apb_req.paddr, IDX_BYTE_B1):
						state_next.prdata[7:0] = state_reg.byte_counter[15:8];
					thc_hit(apb_req.paddr, IDX_BYTE_B2):
						state_next.prdata[7:0] = state_reg.byte_counter[23:16];
					thc_hit(apb_req.paddr, IDX_BYTE_B3):
						state_next.prdata[7:0] = state_reg.byte_counter[31:24];
					thc_hit(apb_req.paddr, IDX_MANUAL):
						state_next.prdata[BIT_FLAG] = state_reg.manual_error_strobe;
					thc_hit(apb_req.paddr, IDX_UPD_REQUEST):
						state_next.prdata[BIT_FLAG] = state_reg.counter_update_request;
					thc_hit(apb_req.paddr, IDX_UPD_STATUS):
						state_next.prdata[BIT_FLAG] = state_reg.counter_update_done;
					default:
						state_next.prdata = '0;
				endcase
			end
		end

		// plain control bits written at the access edge
		if (wr_acc && thc_hit(apb_req.paddr, IDX_IRQ_ENABLE)) begin
			state_next.insertion_finished_irq_en = apb_req.pwdata[BIT_FLAG];
		end
		if (wr_acc && thc_hit(apb_req.paddr, IDX_MANUAL)) begin
			state_next.manual_error_strobe = apb_req.pwdata[BIT_FLAG];
		end
		if (wr_acc && thc_hit(apb_req.paddr, IDX_UPD_REQUEST)) begin
			state_next.counter_update_request = apb_req.pwdata[BIT_FLAG];
		end

		// errored packet tally and live finished flag, new run or disable wins
		if (fin_clear) begin
			state_next.errored_sent_cnt   = '0;
			state_next.insertion_finished = 1'b0;
		end else if (tx_ev.errored_packet_sent) begin
			state_next.errored_sent_cnt = state_reg.errored_sent_cnt + CNT_ONE8;
			if (fin_set) begin
				state_next.insertion_finished = 1'b1;
			end
		end

		// latched flag, a new rise beats a read or a clear in the same cycle
		if (state_next.insertion_finished && !state_reg.insertion_finished) begin
			state_next.insertion_finished_latched = 1'b1;
		end else if (latch_clear) begin
			state_next.insertion_finished_latched = 1'b0;
		end

		// running counters, an event on the update edge starts the new count at one
		if (upd_rise) begin
			state_next.packet_counter = state_reg.pkt_run;
			state_next.byte_counter   = state_reg.byte_run;
			state_next.pkt_run  = tx_ev.packet_sent ? CNT_ONE24 : '0;
			state_next.byte_run = tx_ev.byte_sent ? CNT_ONE32 : '0;
		end else begin
			if (tx_ev.packet_sent) begin
				state_next.pkt_run = state_reg.pkt_run + CNT_ONE24;
			end
			if (tx_ev.byte_sent) begin
				state_next.byte_run = state_reg.byte_run + CNT_ONE32;
			end
		end

		// update status low during the update, set one cycle after the load
		state_next.upd_pending = upd_rise;
		if (state_reg.upd_pending) begin
			state_next.counter_update_done = 1'b1;
		end else if (upd_rise) begin
			state_next.counter_update_done = 1'b0;
		end else if (wr_acc && thc_hit(apb_req.paddr, IDX_UPD_REQUEST)
			&& !apb_req.pwdata[BIT_FLAG]) begin
			state_next.counter_update_done = 1'b0;
		end

		// one cycle error pulse on a gated strobe edge
		state_next.manual_pulse = manual_rise & tx_ev.manual_insert_mode_select;
	end

	// ************************************************************
	// state register
	// ************************************************************

	// single state flop bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************

	// bus answer, zero wait states after the setup cycle
	assign apb_rsp.prdata  = state_reg.prdata;
	assign apb_rsp.pslverr = state_reg.pslverr & apb_req.psel & apb_req.penable;
	assign apb_rsp.pready  = apb_req.psel & apb_req.penable;

	// interrupt level and error strobe
	assign irq = state_reg.insertion_finished_latched
		& state_reg.insertion_finished_irq_en;
	assign manual_error_insert = state_reg.manual_pulse;

	// ************************************************************
	// checks
	// ************************************************************

	sequence upd_load_s;
		upd_rise;
	endsequence

	sequence upd_finish_s;
		##1 (state_reg.upd_pending && !state_reg.counter_update_done)
		##1 state_reg.counter_update_done;
	endsequence

	a_irq_level_gate: assert property (@(posedge pclk) disable iff (!presetn)
		irq == (state_reg.insertion_finished_latched && state_reg.insertion_finished_irq_en))
		else $error("interrupt level does not follow latched flag and enable");

	a_fin_sets_done: assert property (@(posedge pclk) disable iff (!presetn)
		(fin_set && !fin_clear) |=> state_reg.insertion_finished)
		else $error("finished flag not set after last errored packet");

	a_fin_clears_run: assert property (@(posedge pclk) disable iff (!presetn)
		fin_clear |=> !state_reg.insertion_finished && state_reg.errored_sent_cnt == 8'h00)
		else $error("finished flag not cleared on disable or new run");

	a_latch_on_rise: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg.insertion_finished) |-> state_reg.insertion_finished_latched)
		else $error("latched flag missed a rise of the finished flag");

	a_latch_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(latch_clear && !(fin_set && !fin_clear && !state_reg.insertion_finished))
		|=> !state_reg.insertion_finished_latched)
		else $error("latched flag not cleared by read");

	a_pkt_count_step: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_ev.packet_sent && tx_ev.byte_sent && !upd_rise)
		|=> state_reg.pkt_run == $past(state_reg.pkt_run) + CNT_ONE24
		&& state_reg.byte_run == $past(state_reg.byte_run) + CNT_ONE32)
		else $error("running counter did not advance by one");

	a_snap_load_now: assert property (@(posedge pclk) disable iff (!presetn)
		upd_load_s |=> state_reg.packet_counter == $past(state_reg.pkt_run)
		&& state_reg.byte_counter == $past(state_reg.byte_run))
		else $error("snapshot not loaded with running counts");

	a_run_restart_val: assert property (@(posedge pclk) disable iff (!presetn)
		upd_load_s |=> state_reg.pkt_run == {23'h000000, $past(tx_ev.packet_sent)}
		&& state_reg.byte_run == {31'h00000000, $past(tx_ev.byte_sent)})
		else $error("running counter restart value wrong");

	a_upd_done_seq: assert property (@(posedge pclk) disable iff (!presetn)
		upd_load_s |-> upd_finish_s)
		else $error("update status did not set two cycles after request");

	a_upd_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && thc_hit(apb_req.paddr, IDX_UPD_REQUEST) && !apb_req.pwdata[BIT_FLAG]
		&& !state_reg.upd_pending) |=> !state_reg.counter_update_done)
		else $error("update status not cleared by request drop");

	a_manual_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(manual_rise && tx_ev.manual_insert_mode_select)
		|=> manual_error_insert ##1 !manual_error_insert)
		else $error("manual strobe edge did not give one error pulse");

	a_manual_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!(manual_rise && tx_ev.manual_insert_mode_select) |=> !manual_error_insert)
		else $error("error pulse without gated strobe edge");

	a_pkt_byte_map: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_ph && !apb_req.pwrite && thc_hit(apb_req.paddr, IDX_PKT_B2))
		|=> apb_rsp.prdata == {24'h000000, $past(state_reg.packet_counter[23:16])})
		else $error("packet count high byte read wrong");

endmodule
`default_nettype wire

// >>> thc_pkg.sv
// constants, carrier types and register map of the transmit error status and counter bank
package thc_pkg;

	// ************************************************************
	// bus geometry
	// ************************************************************
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PKT_W  = 24;
	localparam int unsigned BYTE_W = 32;

	// ************************************************************
	// register indices, byte address is four times the index
	// ************************************************************
	localparam logic [7:0] IDX_STATUS      = 8'hC8;
	localparam logic [7:0] IDX_LATCHED     = 8'hC9;
	localparam logic [7:0] IDX_IRQ_ENABLE  = 8'hCA;
	localparam logic [7:0] IDX_IRQ_CLEAR   = 8'hCB;
	localparam logic [7:0] IDX_PKT_B0      = 8'hCC;
	localparam logic [7:0] IDX_PKT_B1      = 8'hCD;
	localparam logic [7:0] IDX_PKT_B2      = 8'hCE;
	localparam logic [7:0] IDX_BYTE_B0     = 8'hD0;
	localparam logic [7:0] IDX_BYTE_B1     = 8'hD1;
	localparam logic [7:0] IDX_BYTE_B2     = 8'hD2;
	localparam logic [7:0] IDX_BYTE_B3     = 8'hD3;
	localparam logic [7:0] IDX_MANUAL      = 8'hD4;
	localparam logic [7:0] IDX_UPD_REQUEST = 8'hD6;
	localparam logic [7:0] IDX_UPD_STATUS  = 8'hD7;

	// ************************************************************
	// fields and values
	// ************************************************************
	localparam int unsigned BIT_FLAG         = 0;
	localparam logic [7:0]  TOTAL_CONTINUOUS = 8'hFF;
	localparam logic [7:0]  CNT_ONE8         = 8'h01;
	localparam logic [23:0] CNT_ONE24        = 24'h000001;
	localparam logic [31:0] CNT_ONE32        = 32'h00000001;

	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} thc_apb_req_type;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} thc_apb_rsp_type;

	typedef struct packed {
		logic       packet_sent;
		logic       byte_sent;
		logic       errored_packet_sent;
		logic       auto_insert_initiate;
		logic       insertion_disabled;
		logic [7:0] errored_packet_total;
		logic       manual_insert_mode_select;
	} thc_tx_event_type;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pslverr;
		logic              insertion_finished;
		logic              insertion_finished_latched;
		logic              insertion_finished_irq_en;
		logic [7:0]        errored_sent_cnt;
		logic [PKT_W-1:0]  pkt_run;
		logic [PKT_W-1:0]  packet_counter;
		logic [BYTE_W-1:0] byte_run;
		logic [BYTE_W-1:0] byte_counter;
		logic              manual_error_strobe;
		logic              manual_pulse;
		logic              counter_update_request;
		logic              upd_pending;
		logic              counter_update_done;
	} thc_state_type;

	localparam thc_state_type STATE_RESET = '0;

endpackage

// >>> tx_hdlc_err_status_counters_test.sv
// self-checking testbench of the transmit error status and counter bank
`timescale 1ns/1ps
`default_nettype none
module tx_hdlc_err_status_counters_test;
	import thc_pkg::*;

	// ************************************************************
	// signals and model state
	// ************************************************************
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	thc_apb_req_type  apb_req = '0;
	thc_apb_rsp_type  apb_rsp;
	thc_tx_event_type tx_ev = '0;
	logic             irq;
	logic             manual_error_insert;
	int               mismatches = 0;
	int               checks_done = 0;
	int               pulses = 0;
	int               pkt_m, byte_m, pkt_s, byte_s;
	logic             req_m;
	logic             ev_on = 1'b0;
	logic [31:0]      seed = 32'h0000002B;
	logic             upd_wr;

	// clock at 100 MHz
	always #5 pclk = ~pclk;

	thc_bank i_thc_bank (
		.pclk                (pclk),
		.presetn             (presetn),
		.apb_req             (apb_req),
		.apb_rsp             (apb_rsp),
		.tx_ev               (tx_ev),
		.irq                 (irq),
		.manual_error_insert (manual_error_insert)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	// ************************************************************
	// random traffic and reference counters
	// ************************************************************
	always @(posedge pclk) begin
		seed = xs(seed);
		tx_ev.packet_sent <= ev_on & seed[0] & seed[1];
		tx_ev.byte_sent   <= ev_on & seed[2];
	end

	assign upd_wr = apb_req.psel & apb_req.penable & apb_req.pwrite
		& (apb_req.paddr == ba(IDX_UPD_REQUEST));

	// snapshot on a rising request, restart at 0 or 1, no lost events
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pkt_m = 0; byte_m = 0; pkt_s = 0; byte_s = 0; req_m = 1'b0;
		end else if (upd_wr && apb_req.pwdata[0] && !req_m) begin
			pkt_s = pkt_m;
			byte_s = byte_m;
			pkt_m = int'(tx_ev.packet_sent);
			byte_m = int'(tx_ev.byte_sent);
			req_m = 1'b1;
		end else begin
			pkt_m += int'(tx_ev.packet_sent);
			byte_m += int'(tx_ev.byte_sent);
			if (upd_wr) req_m = apb_req.pwdata[0];
		end
	end

	// counts cycles of the manual error output
	always @(posedge pclk) if (manual_error_insert === 1'b1) pulses++;

	// ************************************************************
	// report, compare and bus tasks
	// ************************************************************
	task automatic test_done;
		if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_pin(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] rd_v, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= w;
		apb_req.paddr <= a;
		apb_req.pwdata <= wd;
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 20);
		if (apb_rsp.pready !== 1'b1) begin
			mismatches++;
			test_done;
		end
		rd_v = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, ba(idx), d, r, e);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string name);
		logic [31:0] r;
		logic        e;
		apb(1'b0, ba(idx), 32'h00000000, r, e);
		chk_reg(name, exp, r);
	endtask

	// one-cycle pulse: 0 errored packet, 1 new run
	task automatic pulse_ev(input int k);
		@(posedge pclk);
		if (k == 0) tx_ev.errored_packet_sent <= 1'b1;
		else tx_ev.auto_insert_initiate <= 1'b1;
		@(posedge pclk);
		tx_ev.errored_packet_sent <= 1'b0;
		tx_ev.auto_insert_initiate <= 1'b0;
	endtask

	task automatic chk_irq(input logic exp);
		@(posedge pclk);
		chk_pin("irq", exp, irq);
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin : main
		logic [7:0]  regs [14];
		logic [31:0] r;
		logic        e;
		int          p0;
		regs = '{IDX_STATUS, IDX_LATCHED, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR, IDX_PKT_B0, IDX_PKT_B1,
			IDX_PKT_B2, IDX_BYTE_B0, IDX_BYTE_B1, IDX_BYTE_B2, IDX_BYTE_B3, IDX_MANUAL,
			IDX_UPD_REQUEST, IDX_UPD_STATUS};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		tx_ev.errored_packet_total <= 8'h03;
		// reset values, read-only write, unmapped and misaligned places
		foreach (regs[i]) rd(regs[i], 32'h00000000, "reset value");
		wr(IDX_STATUS, 32'h00000001);
		rd(IDX_STATUS, 32'h00000000, "status after write");
		apb(1'b0, 12'h33C, 32'h00000000, r, e);
		chk_pin("unmapped error", 1'b1, e);
		chk_reg("unmapped data", 32'h00000000, r);
		apb(1'b1, 12'h321, 32'h00000001, r, e);
		chk_pin("misaligned error", 1'b1, e);
		// counter snapshots under random traffic
		ev_on <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			repeat (20 + int'(seed[4:0])) @(posedge pclk);
			wr(IDX_UPD_REQUEST, 32'h00000001);
			p0 = 0;
			do begin
				apb(1'b0, ba(IDX_UPD_STATUS), 32'h00000000, r, e);
				p0++;
			end while (r !== 32'h00000001 && p0 < 10);
			chk_reg("update done", 32'h00000001, r);
			for (int i = 0; i < 3; i++) rd(8'(IDX_PKT_B0 + i), {24'h000000, pkt_s[8*i +: 8]},
				"packet count");
			for (int i = 0; i < 4; i++) rd(8'(IDX_BYTE_B0 + i), {24'h000000, byte_s[8*i +: 8]},
				"byte count");
			wr(IDX_UPD_REQUEST, 32'h00000000);
			rd(IDX_UPD_STATUS, 32'h00000000, "update done clear");
		end
		ev_on <= 1'b0;
		// manual strobe gated by mode select
		p0 = pulses;
		wr(IDX_MANUAL, 32'h00000000);
		wr(IDX_MANUAL, 32'h00000001);
		repeat (2) @(posedge pclk);
		chk_pin("manual gated", 1'b1, pulses == p0);
		tx_ev.manual_insert_mode_select <= 1'b1;
		wr(IDX_MANUAL, 32'h00000000);
		wr(IDX_MANUAL, 32'h00000001);
		wr(IDX_MANUAL, 32'h00000001);
		repeat (2) @(posedge pclk);
		chk_pin("manual single", 1'b1, pulses == p0 + 1);
		rd(IDX_MANUAL, 32'h00000001, "manual strobe reg");
		// insertion finished, latch, interrupt
		pulse_ev(1);
		repeat (2) pulse_ev(0);
		rd(IDX_STATUS, 32'h00000000, "finished early");
		pulse_ev(0);
		rd(IDX_STATUS, 32'h00000001, "finished");
		chk_irq(1'b0);
		wr(IDX_IRQ_ENABLE, 32'h00000001);
		rd(IDX_IRQ_ENABLE, 32'h00000001, "irq enable");
		chk_irq(1'b1);
		rd(IDX_LATCHED, 32'h00000001, "latched");
		chk_irq(1'b0);
		rd(IDX_LATCHED, 32'h00000000, "latched after read");
		rd(IDX_STATUS, 32'h00000001, "finished holds");
		pulse_ev(1);
		rd(IDX_STATUS, 32'h00000000, "finished new run");
		repeat (3) pulse_ev(0);
		chk_irq(1'b1);
		wr(IDX_IRQ_CLEAR, 32'h00000001);
		chk_irq(1'b0);
		// insertion disabled for one read drops the finished flag, then the disable is released
		tx_ev.insertion_disabled <= 1'b1;
		rd(IDX_STATUS, 32'h00000000, "finished disabled");
		tx_ev.insertion_disabled <= 1'b0;
		// continuous total never finishes, even when the tally reaches it
		tx_ev.errored_packet_total <= 8'hFF;
		pulse_ev(1);
		repeat (255) pulse_ev(0);
		rd(IDX_STATUS, 32'h00000000, "finished continuous");
		rd(IDX_LATCHED, 32'h00000000, "latched continuous");
		test_done;
	end

	// cuts a hang short
	initial begin
		repeat (50000) @(posedge pclk);
		mismatches++;
		test_done;
	end

endmodule
`default_nettype wire
